// ---- hdl/ir_relay_pkg.sv ----
package ir_relay_pkg;
  // Nonvolatile cell offsets
  localparam logic [5:0] ADDR_PULSE_CTRL = 6'h02;
  localparam logic [5:0] ADDR_HYST = 6'h20;
  localparam logic [5:0] ADDR_THRESH = 6'h21;
  // RAM result cell offsets
  localparam logic [7:0] RAM_AMBIENT = 8'h06;
  localparam logic [7:0] RAM_OBJ1 = 8'h07;
  localparam logic [7:0] RAM_OBJ2 = 8'h08;
  // Control word bit positions
  localparam int BIT_PULSE_EN = 1;
  localparam int BIT_DRIVE_TYPE = 2;
  localparam int BIT_RELAY_SEL = 3;
  // Ambient linearisation limits, 0.02 K per lsb
  localparam logic [15:0] AMB_CODE_MIN = 16'h2de4;
  localparam logic [15:0] AMB_CODE_MAX = 16'h4dc4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  // Hold time for the bus request, in microseconds, and its cycle count at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int REQ_HOLD_US = 2000;
  localparam int REQ_HOLD_CYC = REQ_HOLD_US * CLK_MHZ;
  localparam int INIT_CYC = 16;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_AMB = 3'b001,
    ST_COMMON = 3'b010,
    ST_OBJ1 = 3'b011,
    ST_OBJ2 = 3'b100,
    ST_PULSE = 3'b101
  } loop_state_t;
endpackage : ir_relay_pkg

// ---- hdl/ir_temp_result_and_relay.sv ----
`timescale 1ns/1ps
// Operation
// RULE_01: Ambient result stays in RAM cell 006h, clamped to 2DE4h..4DC4h.
// RULE_02: Ambient code times 0.02 gives kelvin.
// RULE_03: Object results are stored as kelvin over 0.02 codes.
// RULE_04: After reset load calibration, pick sensor count and die sensor type.
// RULE_05: After init the measurement loop repeats forever with no request.
// RULE_06: Ambient path: offset, programmable FIR, compensation, IIR, calculation; the code applies only the offset filter, the IIR and the clamp.
// RULE_07: Common path: offset and gain filtered, gain factor stored.
// RULE_08: Each object channel compensated and filtered; channel two skipped if single.
// RULE_09: Each loop ends by rescaling the selected result to 10 bits.
// RULE_10: All programmable FIRs share one length, all IIRs another; the FIR length is captured but no FIR stage uses it.
// RULE_11: Relay works only with relay select and pulse output enable set.
// RULE_12: Relay compares first object temperature, gives a logic level.
// RULE_13: Pin is push-pull or open-drain per drive type bit.
// RULE_14: Threshold from cell 021h, hysteresis from cell 020h.
// RULE_15: Output high when object >= threshold plus hysteresis.
// RULE_16: Output low when object <= threshold minus hysteresis.
// RULE_17: Between the levels the output holds its state.
// RULE_18: Relay mode keeps measuring and accepts the bus entry request.
// RULE_19: After bus entry relay stays off until a reset such as sleep exit.
// RULE_20: Serial clock low past hold time disables output, frees the pin.
// RULE_21: Disabled output returns only after power cycle or sleep exit.
module ir_temp_result_and_relay
  import ir_relay_pkg::*;
#(
  parameter int REQ_CYC = REQ_HOLD_CYC,
  parameter int FILT_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sleep_exit_i,
  input wire logic [15:0] nv_pulse_ctrl_i,
  input wire logic [15:0] nv_hyst_i,
  input wire logic [15:0] nv_thresh_i,
  input wire logic [FILT_W-1:0] nv_fir_len_i,
  input wire logic [FILT_W-1:0] nv_iir_len_i,
  input wire logic nv_dual_sensor_i,
  input wire logic nv_die_ptat_i,
  input wire logic [1:0] nv_pulse_sel_i,
  input wire logic [15:0] amb_sample_i,
  input wire logic [15:0] obj1_sample_i,
  input wire logic [15:0] obj2_sample_i,
  input wire logic [15:0] amb_offset_i,
  input wire logic [15:0] ir_offset_i,
  input wire logic scl_pin_i,
  input wire logic [7:0] ram_addr_i,
  output logic [15:0] ram_data_o,
  output logic [15:0] ctrl_word_o,
  output logic [15:0] hyst_o,
  output logic [15:0] thresh_o,
  output logic [15:0] ambient_die_temp_o,
  output logic [15:0] first_object_temp_o,
  output logic [15:0] second_object_temp_o,
  output logic [15:0] gain_compensation_factor_o,
  output logic [9:0] pulse_value_o,
  output logic pulse_load_o,
  output logic pulse_enabled_o,
  output logic relay_active_o,
  output logic die_ptat_o,
  output logic dual_sensor_o,
  output logic bus_mode_o,
  output logic sda_out_o,
  output logic sda_oe_o
);

  // Two-stage synchroniser for the serial clock pin
  logic scl_s1_q, scl_s2_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_pin_i;
      scl_s2_q <= scl_s1_q;
    end
  end

  function automatic logic [15:0] filt(input logic [15:0] prev, input logic [15:0] smp,
                                        input logic [FILT_W-1:0] sh);
    logic signed [17:0] diff;
    diff = $signed({2'b00, smp}) - $signed({2'b00, prev});
    filt = prev + 16'(diff >>> sh);
  endfunction : filt

  loop_state_t st_q, st_d;
  logic [7:0] init_cnt_q, init_cnt_d;
  logic [15:0] ctrl_q, ctrl_d, hyst_q, hyst_d, thr_q, thr_d;
  logic [FILT_W-1:0] fir_len_q, fir_len_d, iir_len_q, iir_len_d;
  logic dual_q, dual_d, ptat_q, ptat_d;
  logic [15:0] amb_q, amb_d, o1_q, o1_d, o2_q, o2_d, kg_q, kg_d;
  logic [15:0] amb_os_q, amb_os_d, ir_os_q, ir_os_d;
  logic [9:0] pv_q, pv_d;
  logic load_q, load_d;
  logic [31:0] req_cnt_q, req_cnt_d;
  logic bus_q, bus_d, relay_q, relay_d;
  logic [15:0] ram_q, ram_d;
  logic [16:0] hi_lvl, lo_lvl, amb_c;
  logic [15:0] pmin, pmax, pval, span;
  logic [25:0] scaled;
  logic pulse_en, relay_on;

  assign pulse_en = ctrl_q[BIT_PULSE_EN] & ~bus_q;
  assign relay_on = pulse_en & ctrl_q[BIT_RELAY_SEL]; // RULE_11 RULE_19

  always_comb begin
    st_d = st_q;
    init_cnt_d = init_cnt_q;
    ctrl_d = ctrl_q;
    hyst_d = hyst_q;
    thr_d = thr_q;
    fir_len_d = fir_len_q;
    iir_len_d = iir_len_q;
    dual_d = dual_q;
    ptat_d = ptat_q;
    amb_d = amb_q;
    o1_d = o1_q;
    o2_d = o2_q;
    kg_d = kg_q;
    amb_os_d = amb_os_q;
    ir_os_d = ir_os_q;
    pv_d = pv_q;
    load_d = 1'b0;
    amb_c = 17'h00000;
    pmin = 16'h0000;
    pmax = 16'h0000;
    pval = 16'h0000;
    span = 16'h0000;
    scaled = 26'h0000000;
    unique case (st_q)
      ST_INIT: begin
        // Calibration cells are captured, sensor count and die sensor chosen
        ctrl_d = nv_pulse_ctrl_i; // RULE_04
        hyst_d = nv_hyst_i; // RULE_14
        thr_d = nv_thresh_i; // RULE_14
        fir_len_d = nv_fir_len_i; // RULE_10
        iir_len_d = nv_iir_len_i; // RULE_10
        dual_d = nv_dual_sensor_i; // RULE_04
        ptat_d = nv_die_ptat_i; // RULE_04
        init_cnt_d = init_cnt_q + 8'h01;
        if (init_cnt_q == 8'(INIT_CYC - 1)) begin
          st_d = ST_AMB;
        end
      end
      ST_AMB: begin
        amb_os_d = filt(amb_os_q, amb_offset_i, FILT_W'(1)); // RULE_06
        amb_c = {1'b0, filt(amb_q, amb_sample_i - amb_os_q, iir_len_q)}; // RULE_06
        // Linearisation is bounded to the ambient code range
        if (amb_c[15:0] < AMB_CODE_MIN) begin
          amb_d = AMB_CODE_MIN; // RULE_01
        end else if (amb_c[15:0] > AMB_CODE_MAX) begin
          amb_d = AMB_CODE_MAX; // RULE_01 RULE_02
        end else begin
          amb_d = amb_c[15:0];
        end
        st_d = ST_COMMON;
      end
      ST_COMMON: begin
        ir_os_d = filt(ir_os_q, ir_offset_i, FILT_W'(1)); // RULE_07
        kg_d = filt(kg_q, 16'h8000 - ir_os_q, FILT_W'(1)); // RULE_07
        st_d = ST_OBJ1;
      end
      ST_OBJ1: begin
        o1_d = filt(o1_q, obj1_sample_i - ir_os_q, iir_len_q); // RULE_08 RULE_03
        st_d = dual_q ? ST_OBJ2 : ST_PULSE; // RULE_08
      end
      ST_OBJ2: begin
        o2_d = filt(o2_q, obj2_sample_i - ir_os_q, iir_len_q); // RULE_08 RULE_03
        st_d = ST_PULSE;
      end
      ST_PULSE: begin
        pmin = thr_q;
        pmax = hyst_q;
        pval = (nv_pulse_sel_i == 2'b00) ? amb_q : (nv_pulse_sel_i == 2'b10) ? o2_q : o1_q;
        span = pmax - pmin;
        if (pval <= pmin || span == 16'h0000) begin
          pv_d = 10'h000;
        end else if (pval >= pmax) begin
          pv_d = 10'h3ff;
        end else begin
          scaled = 26'((pval - pmin) * 26'd1023 / {10'h000, span}); // RULE_09
          pv_d = scaled[9:0];
        end
        load_d = 1'b1; // RULE_09
        st_d = ST_AMB; // RULE_05
      end
      default: st_d = ST_INIT;
    endcase
  end

  // Bus request detection and the relay comparator
  always_comb begin
    req_cnt_d = req_cnt_q;
    bus_d = bus_q;
    relay_d = relay_q;
    hi_lvl = {1'b0, thr_q} + {1'b0, hyst_q};
    lo_lvl = {1'b0, thr_q} - {1'b0, hyst_q};
    // A request that completes in the same cycle as a sleep exit still wins
    if (sleep_exit_i) begin
      bus_d = 1'b0; // RULE_21 RULE_19
      req_cnt_d = 32'h00000000;
    end
    if (!bus_q && ctrl_q[BIT_PULSE_EN]) begin
      if (scl_s2_q) begin
        req_cnt_d = 32'h00000000;
      end else if (req_cnt_q >= 32'(REQ_CYC)) begin
        bus_d = 1'b1; // RULE_20 RULE_18
      end else begin
        req_cnt_d = req_cnt_q + 32'h00000001;
      end
    end
    if (relay_on && st_q != ST_INIT) begin
      if ({1'b0, o1_q} >= hi_lvl) begin
        relay_d = 1'b1; // RULE_15 RULE_12
      end else if (!lo_lvl[16] && {1'b0, o1_q} <= lo_lvl) begin
        relay_d = 1'b0; // RULE_16
      end
      // Otherwise hold, giving the hysteresis band RULE_17
    end
  end

  always_comb begin
    unique case (ram_addr_i)
      RAM_AMBIENT: ram_d = amb_q;
      RAM_OBJ1: ram_d = o1_q;
      RAM_OBJ2: ram_d = o2_q;
      default: ram_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_INIT;
      init_cnt_q <= 8'h00;
      ctrl_q <= CTRL_RESET;
      hyst_q <= TEMP_RESET;
      thr_q <= TEMP_RESET;
      fir_len_q <= '0;
      iir_len_q <= '0;
      dual_q <= 1'b0;
      ptat_q <= 1'b0;
      amb_q <= AMB_CODE_MIN;
      o1_q <= TEMP_RESET;
      o2_q <= TEMP_RESET;
      kg_q <= TEMP_RESET;
      amb_os_q <= TEMP_RESET;
      ir_os_q <= TEMP_RESET;
      pv_q <= 10'h000;
      load_q <= 1'b0;
      req_cnt_q <= 32'h00000000;
      bus_q <= 1'b0;
      relay_q <= 1'b0;
      ram_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      init_cnt_q <= init_cnt_d;
      ctrl_q <= ctrl_d;
      hyst_q <= hyst_d;
      thr_q <= thr_d;
      fir_len_q <= fir_len_d;
      iir_len_q <= iir_len_d;
      dual_q <= dual_d;
      ptat_q <= ptat_d;
      amb_q <= amb_d;
      o1_q <= o1_d;
      o2_q <= o2_d;
      kg_q <= kg_d;
      amb_os_q <= amb_os_d;
      ir_os_q <= ir_os_d;
      pv_q <= pv_d;
      load_q <= load_d;
      req_cnt_q <= req_cnt_d;
      bus_q <= bus_d;
      relay_q <= relay_d;
      ram_q <= ram_d;
    end
  end

  // Pin drive registered so outputs come straight from flops
  logic sda_out_q, sda_oe_q, relay_act_q, pen_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
      relay_act_q <= 1'b0;
      pen_q <= 1'b0;
    end else begin
      relay_act_q <= relay_on;
      pen_q <= pulse_en;
      if (relay_on) begin
        // Open-drain only pulls low; push-pull drives both levels
        sda_out_q <= relay_q; // RULE_12
        sda_oe_q <= ctrl_q[BIT_DRIVE_TYPE] ? 1'b1 : ~relay_q; // RULE_13
      end else begin
        sda_out_q <= 1'b0;
        sda_oe_q <= 1'b0; // RULE_20
      end
    end
  end

  assign ram_data_o = ram_q;
  assign ctrl_word_o = ctrl_q;
  assign hyst_o = hyst_q;
  assign thresh_o = thr_q;
  assign ambient_die_temp_o = amb_q;
  assign first_object_temp_o = o1_q;
  assign second_object_temp_o = o2_q;
  assign gain_compensation_factor_o = kg_q;
  assign pulse_value_o = pv_q;
  assign pulse_load_o = load_q;
  assign pulse_enabled_o = pen_q;
  assign relay_active_o = relay_act_q;
  assign die_ptat_o = ptat_q;
  assign dual_sensor_o = dual_q;
  assign bus_mode_o = bus_q;
  assign sda_out_o = sda_out_q;
  assign sda_oe_o = sda_oe_q;

endmodule : ir_temp_result_and_relay

// ---- verification/relay_props.sv ----
`timescale 1ns/1ps
module relay_props
  import ir_relay_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sleep_exit_i,
  input wire logic [7:0] ram_addr_i,
  input wire logic [15:0] ram_data_o,
  input wire logic [15:0] ctrl_word_o,
  input wire logic [15:0] hyst_o,
  input wire logic [15:0] thresh_o,
  input wire logic [15:0] ambient_die_temp_o,
  input wire logic [15:0] first_object_temp_o,
  input wire logic pulse_load_o,
  input wire logic relay_active_o,
  input wire logic dual_sensor_o,
  input wire logic bus_mode_o,
  input wire logic sda_out_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire [16:0] hi_lvl = {1'b0, thresh_o} + {1'b0, hyst_o};
  wire [16:0] lo_lvl = {1'b0, thresh_o} - {1'b0, hyst_o};
  wire above = {1'b0, first_object_temp_o} >= hi_lvl;
  wire below = !lo_lvl[16] && first_object_temp_o <= lo_lvl[15:0];
  wire relay_live = relay_active_o && !bus_mode_o;
  sequence live2;
    relay_live ##1 relay_live;
  endsequence
  // Single loop is four states, dual five, so the load pulse repeats every 4 or 5 cycles
  sequence quiet3;
    !pulse_load_o [*3];
  endsequence
  amb_range_a: assert property (
    ambient_die_temp_o >= AMB_CODE_MIN && ambient_die_temp_o <= AMB_CODE_MAX)
    else $error("ambient out of range");
  ram_ambient_a: assert property (
    ram_addr_i == RAM_AMBIENT |=> ram_data_o == $past(ambient_die_temp_o))
    else $error("ambient cell read wrong");
  ram_object_a: assert property (
    ram_addr_i == RAM_OBJ1 |=> ram_data_o == $past(first_object_temp_o))
    else $error("object cell read wrong");
  relay_high_a: assert property (live2 ##0 above |-> ##2 (sda_out_o || bus_mode_o))
    else $error("relay did not go high");
  relay_low_a: assert property (live2 ##0 below |-> ##2 (!sda_out_o || bus_mode_o))
    else $error("relay did not go low");
  relay_hold_a: assert property (
    live2 ##0 (!above && !below) |-> ##2 (sda_out_o == $past(sda_out_o) || bus_mode_o))
    else $error("relay changed inside band");
  relay_enable_a: assert property (
    relay_active_o |-> ctrl_word_o[BIT_RELAY_SEL] && ctrl_word_o[BIT_PULSE_EN])
    else $error("relay active without enables");
  open_drain_a: assert property (
    !ctrl_word_o[BIT_DRIVE_TYPE] |-> !(sda_oe_o && sda_out_o))
    else $error("open drain pin driven high");
  bus_release_a: assert property (bus_mode_o |=> !sda_oe_o)
    else $error("pin not released");
  bus_sticky_a: assert property (bus_mode_o && !sleep_exit_i |=> bus_mode_o)
    else $error("bus mode lost");
  loop_gap_a: assert property (pulse_load_o |=> quiet3)
    else $error("loop too short");
  loop_period_a: assert property (pulse_load_o |-> ##4 (pulse_load_o != dual_sensor_o))
    else $error("loop length wrong");
endmodule : relay_props

bind ir_temp_result_and_relay relay_props u_props (.clk_sys_i, .reset_n_i, .sleep_exit_i,
  .ram_addr_i, .ram_data_o, .ctrl_word_o, .hyst_o, .thresh_o, .ambient_die_temp_o,
  .first_object_temp_o, .pulse_load_o, .relay_active_o, .dual_sensor_o, .bus_mode_o,
  .sda_out_o, .sda_oe_o);

// ---- verification/smbus_far_side.sv ----
`timescale 1ns/1ps
module smbus_far_side (
  input wire logic clk_sys_i,
  input wire logic hold_low_i,
  input wire logic sda_out_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic pin_o
);
  initial scl_o = 1'b1;
  // Host pulls the clock low only on command; the pull-up holds it high otherwise
  always @(posedge clk_sys_i) scl_o <= !hold_low_i;
  // Pull-up wins whenever the device leaves the shared pin undriven
  assign pin_o = sda_oe_i ? sda_out_i : 1'b1;
endmodule : smbus_far_side

// ---- verification/test_ir_temp_result_and_relay.sv ----
`timescale 1ns/1ps
module test_ir_temp_result_and_relay;
  import ir_relay_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sleep_exit_i = 1'b0;
  logic hold_low = 1'b0;
  logic dual = 1'b0;
  logic [15:0] ctrl = 16'h0000;
  logic [15:0] obj1 = 16'h0000;
  logic [15:0] amb = 16'h0000;
  logic [7:0] addr = 8'h00;
  logic [1:0] psel = 2'b01;
  logic [15:0] amb_os = 16'h0000;
  logic [15:0] ir_os = 16'h0000;
  logic scl, pin, bus_mode, relay_on, oe, out, dual_o, die_o, load, pen;
  logic [9:0] pv;
  logic [15:0] ram_data, ctrl_o, hyst, thr, amb_t, obj_t, obj2_t, kg;
  int checked = 0;
  int miscompares = 0;
  int cycles = 0;
  int n;
  always #5 clk_sys_i = ~clk_sys_i;
  ir_temp_result_and_relay #(.REQ_CYC(20)) dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .sleep_exit_i(sleep_exit_i), .nv_pulse_ctrl_i(ctrl), .nv_hyst_i(16'h0064),
    .nv_thresh_i(16'h6ca7), .nv_fir_len_i(4'h2), .nv_iir_len_i(4'h1), .nv_dual_sensor_i(dual),
    .nv_die_ptat_i(dual), .nv_pulse_sel_i(psel), .amb_sample_i(amb), .obj1_sample_i(obj1),
    .obj2_sample_i(obj1), .amb_offset_i(amb_os), .ir_offset_i(ir_os), .scl_pin_i(scl),
    .ram_addr_i(addr), .ram_data_o(ram_data), .ctrl_word_o(ctrl_o), .hyst_o(hyst),
    .thresh_o(thr), .ambient_die_temp_o(amb_t), .first_object_temp_o(obj_t),
    .second_object_temp_o(obj2_t), .gain_compensation_factor_o(kg), .pulse_value_o(pv),
    .pulse_load_o(load), .pulse_enabled_o(pen), .relay_active_o(relay_on), .die_ptat_o(die_o),
    .dual_sensor_o(dual_o), .bus_mode_o(bus_mode), .sda_out_o(out), .sda_oe_o(oe));
  smbus_far_side host (.clk_sys_i(clk_sys_i), .hold_low_i(hold_low), .sda_out_i(out),
    .sda_oe_i(oe), .scl_o(scl), .pin_o(pin));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic setup(input logic [15:0] c, input logic two);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    ctrl <= c;
    dual <= two;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // Init takes a fixed 16 cycles; a few spare let the captured values land
    repeat (20) @(posedge clk_sys_i);
  endtask : setup
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    repeat (2) @(posedge clk_sys_i);
    chk(ram_data, exp);
  endtask : rd
  // Moves the object past one switching level, then checks the pin three cycles later
  task automatic relay_to(input logic [15:0] s, input logic up, input logic exp);
    obj1 <= s;
    for (n = 0; n < 3000 && !(up ? obj_t >= 16'h6d0b : obj_t <= 16'h6c43); n++)
      @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
    chk({15'h0, pin}, {15'h0, exp});
  endtask : relay_to
  task automatic scl_low(input int len);
    hold_low <= 1'b1;
    repeat (len) @(posedge clk_sys_i);
    hold_low <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask : scl_low
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    setup(16'h000e, 1'b1);
    chk(ctrl_o, 16'h000e);
    chk(thr, 16'h6ca7);
    chk(hyst, 16'h0064);
    chk({14'h0, dual_o, die_o}, 16'h0003);
    chk({15'h0, relay_on}, 16'h0001);
    chk({15'h0, pen}, 16'h0001);
    relay_to(16'hc000, 1'b1, 1'b1);
    chk({15'h0, oe}, 16'h0001);
    chk({6'h00, pv}, 16'h03ff);
    relay_to(16'h1000, 1'b0, 1'b0);
    amb <= 16'h7000;
    for (n = 0; n < 3000 && amb_t !== AMB_CODE_MAX; n++) @(posedge clk_sys_i);
    rd(RAM_AMBIENT, 16'h4dc4);
    amb <= 16'h1000;
    for (n = 0; n < 3000 && amb_t !== AMB_CODE_MIN; n++) @(posedge clk_sys_i);
    rd(RAM_AMBIENT, 16'h2de4);
    rd(8'h30, 16'h0000);
    scl_low(10);
    chk({15'h0, bus_mode}, 16'h0000);
    scl_low(30);
    chk({15'h0, bus_mode}, 16'h0001);
    chk({15'h0, pen}, 16'h0000);
    relay_to(16'hc000, 1'b1, 1'b1);
    relay_to(16'h1000, 1'b0, 1'b1);
    // Falling toward its target the first-order filter lands on it exactly
    for (n = 0; n < 3000 && obj_t !== 16'h1000; n++) @(posedge clk_sys_i);
    rd(RAM_OBJ1, 16'h1000);
    rd(RAM_OBJ2, 16'h1000);
    chk(obj2_t, 16'h1000);
    chk({6'h00, pv}, 16'h0000);
    // Rising toward 8000h with no offset it settles one code short
    chk(kg, 16'h7fff);
    for (n = 0; n < 20 && load !== 1'b1; n++) @(posedge clk_sys_i);
    chk({15'h0, load}, 16'h0001);
    sleep_exit_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_exit_i <= 1'b0;
    for (n = 0; n < 50 && relay_on !== 1'b1; n++) @(posedge clk_sys_i);
    chk({14'h0, bus_mode, relay_on}, 16'h0001);
    psel <= 2'b10;
    setup(16'h000a, 1'b0);
    chk({15'h0, dual_o}, 16'h0000);
    relay_to(16'hc000, 1'b1, 1'b1);
    chk({15'h0, oe}, 16'h0000);
    // Channel two is skipped, so the selected second result stays at its reset value
    chk(obj2_t, 16'h0000);
    chk({6'h00, pv}, 16'h0000);
    relay_to(16'h1000, 1'b0, 1'b0);
    setup(16'h0008, 1'b0);
    chk({15'h0, relay_on}, 16'h0000);
    chk({15'h0, pen}, 16'h0000);
    scl_low(30);
    chk({15'h0, bus_mode}, 16'h0000);
    conclude();
  end
endmodule : test_ir_temp_result_and_relay
